// ==== hdl/sgoc_buf.sv ====
`timescale 1ns/1ps
module sgoc_buf (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [sgoc_pkg::BUF_W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [sgoc_pkg::BUF_W-1:0] out_data_o
);

    typedef struct packed {
        logic [sgoc_pkg::BUF_DEPTH-1:0][sgoc_pkg::BUF_W-1:0] mem;
        logic wptr;
        logic rptr;
        logic [1:0] cnt;
    } sgoc_buf_t;

    sgoc_buf_t st;
    sgoc_buf_t next_st;
    logic push;
    logic pop;

    // ****************************************
    // Two-entry FIFO
    // ****************************************
    assign in_ready_o = ce_i & (st.cnt != 2'h2);
    assign out_valid_o = st.cnt != 2'h0;
    assign out_data_o = st.mem[st.rptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = ce_i & out_valid_o & out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data_i;
            next_st.wptr = ~st.wptr;
        end
        if (pop) begin
            next_st.rptr = ~st.rptr;
        end
        next_st.cnt = 2'(st.cnt + {1'h0, push} - {1'h0, pop});
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

endmodule : sgoc_buf

// ==== hdl/sgoc_core.sv ====
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module sgoc_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sgoc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic smp_valid_i,
    output logic smp_ready_o,
    input wire logic [sgoc_pkg::SMP_W-1:0] smp_data_i,
    input wire logic smp_chan_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [sgoc_pkg::SMP_W-1:0] out_data_o,
    output logic out_chan_o,
    output logic out_odd_o
);

    typedef struct packed {
        logic [3:0][sgoc_pkg::REG_W-1:0] corr;
        logic gain_en;
        logic ofs_en;
        logic [1:0] odd_next;
        logic [15:0] cnt;
        logic ack;
        logic [31:0] rdat;
    } sgoc_core_t;

    sgoc_core_t st;
    sgoc_core_t next_st;

    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic [2:0] corr_slot(input logic [7:0] idx);
        logic [7:0] rel;
        rel = 8'(idx - sgoc_pkg::IDX_CH14_ODD);
        corr_slot = {(idx >= sgoc_pkg::IDX_CH14_ODD)
            && (idx <= sgoc_pkg::IDX_CH15_EVEN), rel[1:0]};
    endfunction : corr_slot

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction : merge16

    logic [7:0] idx;
    logic [2:0] hit;
    logic bus_go;
    logic [15:0] ctrl_wr;
    logic [1:0] smp_slot;
    logic [15:0] sel_reg;
    logic signed [sgoc_pkg::OFS_W-1:0] ofs;
    logic signed [sgoc_pkg::DIFF_W-1:0] diff;
    logic signed [sgoc_pkg::SMP_W-1:0] gained;
    logic take;
    logic buf_ready;
    logic [sgoc_pkg::BUF_W-1:0] buf_out;
    logic cur_odd;

    assign idx = wb_adr_i[9:2];
    assign hit = corr_slot(idx);
    assign bus_go = ce_i & wb_cyc_i & wb_stb_i & ~st.ack;
    assign ctrl_wr = merge16(16'h0000, wb_dat_i, wb_sel_i);

    // ****************************************
    // Sample path
    // ****************************************
    assign cur_odd = st.odd_next[smp_chan_i];
    assign smp_slot = {smp_chan_i, ~cur_odd};
    assign sel_reg = st.corr[smp_slot];
    assign ofs = sel_reg[sgoc_pkg::OFS_MSB:sgoc_pkg::OFS_LSB];

    localparam int DIFF_W = sgoc_pkg::DIFF_W;

    always_comb begin
        diff = DIFF_W'($signed(smp_data_i));
        if (st.ofs_en) begin
            diff = DIFF_W'($signed(smp_data_i)) - DIFF_W'(ofs);
        end
    end

    sgoc_gain u_gain (
        .x_i(diff),
        .code_i(sel_reg[sgoc_pkg::GAIN_MSB:sgoc_pkg::GAIN_LSB]),
        .en_i(st.gain_en),
        .y_o(gained)
    );

    assign smp_ready_o = buf_ready;
    assign take = smp_valid_i & buf_ready;

    sgoc_buf u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(smp_valid_i),
        .in_ready_o(buf_ready),
        .in_data_i({cur_odd, smp_chan_i, gained}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(buf_out)
    );

    assign out_data_o = buf_out[sgoc_pkg::SMP_W-1:0];
    assign out_chan_o = buf_out[sgoc_pkg::SMP_W];
    assign out_odd_o = buf_out[sgoc_pkg::SMP_W+1];

    // ****************************************
    // Registers and bus
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack = bus_go;
        next_st.rdat = 32'h00000000;
        if (bus_go && !wb_we_i) begin
            if (hit[2]) begin
                next_st.rdat[15:0] = st.corr[hit[1:0]];
            end else if (idx == sgoc_pkg::IDX_CTRL) begin
                next_st.rdat[sgoc_pkg::GAIN_EN_BIT] = st.gain_en;
                next_st.rdat[sgoc_pkg::OFS_EN_BIT] = st.ofs_en;
            end else if (idx == sgoc_pkg::IDX_STATUS) begin
                next_st.rdat[sgoc_pkg::ST_ODD14_BIT] = st.odd_next[0];
                next_st.rdat[sgoc_pkg::ST_ODD15_BIT] = st.odd_next[1];
                next_st.rdat[sgoc_pkg::ST_PEND_BIT] = out_valid_o;
                next_st.rdat[31:sgoc_pkg::ST_CNT_LSB] = st.cnt;
            end
        end
        if (bus_go && wb_we_i) begin
            if (hit[2]) begin
                next_st.corr[hit[1:0]] =
                    merge16(st.corr[hit[1:0]], wb_dat_i, wb_sel_i);
            end else if (idx == sgoc_pkg::IDX_CTRL) begin
                if (wb_sel_i[1]) begin
                    next_st.gain_en = ctrl_wr[sgoc_pkg::GAIN_EN_BIT];
                    next_st.ofs_en = ctrl_wr[sgoc_pkg::OFS_EN_BIT];
                end
                if (wb_sel_i[0] && ctrl_wr[sgoc_pkg::PAR_CLR_BIT]) begin
                    next_st.odd_next = 2'h0;
                end
            end
        end
        // A taken sample wins over a parity restart in one cycle
        if (take) begin
            next_st.odd_next[smp_chan_i] = ~cur_odd;
            next_st.cnt = 16'(st.cnt + 16'h0001);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.corr <= {4{sgoc_pkg::CORR_RST}};
            st.gain_en <= sgoc_pkg::CTRL_EN_RST;
            st.ofs_en <= sgoc_pkg::CTRL_EN_RST;
            st.odd_next <= 2'h0;
            st.cnt <= sgoc_pkg::CNT_RST;
            st.ack <= 1'h0;
            st.rdat <= 32'h00000000;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdat;
    assign wb_ack_o = st.ack;

endmodule : sgoc_core

// ==== hdl/sgoc_gain.sv ====
`timescale 1ns/1ps
module sgoc_gain (
    input wire logic signed [sgoc_pkg::DIFF_W-1:0] x_i,
    input wire logic [sgoc_pkg::GAIN_W-1:0] code_i,
    input wire logic en_i,
    output logic signed [sgoc_pkg::SMP_W-1:0] y_o
);

    // ****************************************
    // Linear factor 10^(N/100) in Q2.14
    // ****************************************
    localparam logic [15:0] COEF [32] = '{
        16'h4000, 16'h417e, 16'h4304, 16'h4494,
        16'h462d, 16'h47cf, 16'h497b, 16'h4b32,
        16'h4cf2, 16'h4ebd, 16'h5092, 16'h5273,
        16'h545e, 16'h5655, 16'h5858, 16'h5a67,
        16'h5c82, 16'h5eaa, 16'h60de, 16'h6320,
        16'h656f, 16'h67cc, 16'h6a37, 16'h6cb0,
        16'h6f38, 16'h71cf, 16'h7476, 16'h772c,
        16'h79f3, 16'h7cca, 16'h7fb2, 16'h82ac
    };
    localparam logic signed [31:0] HALF = 32'sh00002000;
    localparam logic signed [31:0] MAXV = 32'sh00001fff;
    localparam logic signed [31:0] MINV = -32'sh00002000;

    logic signed [sgoc_pkg::COEF_W-1:0] coef;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;

    always_comb begin
        coef = $signed({1'h0, COEF[0]});
        if (en_i) begin
            coef = $signed({1'h0, COEF[code_i]});
        end
        prod = 32'(x_i) * 32'(coef);
        scaled = (prod + HALF) >>> sgoc_pkg::COEF_FRAC;
        if (scaled > MAXV) begin
            y_o = MAXV[sgoc_pkg::SMP_W-1:0];
        end else if (scaled < MINV) begin
            y_o = MINV[sgoc_pkg::SMP_W-1:0];
        end else begin
            y_o = scaled[sgoc_pkg::SMP_W-1:0];
        end
    end

endmodule : sgoc_gain

// ==== hdl/sgoc_pkg.sv ====
// How it works
// - The five-bit gain field (bits 15..11) is applied only while the global gain enable (control bit 12) is one.
// - A gain code N scales the sample by N times 0.2 dB.
// - The offset field (bits 9..0) is subtracted only while the global offset enable (control bit 8) is one.
// - The offset is a signed 10-bit value whose LSB is one LSB of the 14-bit sample.
// - Each channel has its own even and odd settings, each used only on samples of that parity.
// - Settings sit at index 33h (ch14 odd), 34h (ch14 even), 35h (ch15 odd) and 36h (ch15 even).
package sgoc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int SMP_W = 14;
    localparam int DIFF_W = 15;
    localparam int OFS_W = 10;
    localparam int GAIN_W = 5;
    localparam int REG_W = 16;
    localparam int ADR_W = 10;
    localparam int COEF_W = 17;
    localparam int COEF_FRAC = 14;
    localparam int BUF_W = 16;
    localparam int BUF_DEPTH = 2;

    // ****************************************
    // Register indices (byte address is 4x)
    // ****************************************
    localparam logic [7:0] IDX_CTRL = 8'h03;
    localparam logic [7:0] IDX_CH14_ODD = 8'h33;
    localparam logic [7:0] IDX_CH14_EVEN = 8'h34;
    localparam logic [7:0] IDX_CH15_ODD = 8'h35;
    localparam logic [7:0] IDX_CH15_EVEN = 8'h36;
    localparam logic [7:0] IDX_STATUS = 8'h3e;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int GAIN_MSB = 15;
    localparam int GAIN_LSB = 11;
    localparam int RSVD_BIT = 10;
    localparam int OFS_MSB = 9;
    localparam int OFS_LSB = 0;
    localparam int GAIN_EN_BIT = 12;
    localparam int OFS_EN_BIT = 8;
    localparam int PAR_CLR_BIT = 0;
    localparam int ST_ODD14_BIT = 0;
    localparam int ST_ODD15_BIT = 1;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_CNT_LSB = 16;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] CORR_RST = 16'h0000;
    localparam logic CTRL_EN_RST = 1'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;

endpackage : sgoc_pkg

// ==== verification/sgoc_core_asserts.sv ====
`timescale 1ns/1ps
module sgoc_core_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sgoc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic smp_valid_i,
    input wire logic smp_ready_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [sgoc_pkg::SMP_W-1:0] out_data_o,
    input wire logic out_chan_o,
    input wire logic out_odd_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] nxt_odd;
    logic par_clr;
    sequence bus_req;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
    endsequence
    sequence pop;
        out_valid_o && out_ready_i && ce_i;
    endsequence
    // Parity expected next per channel
    // Parity restart written through the control register
    assign par_clr = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o
        && wb_we_i && (wb_adr_i[9:2] == sgoc_pkg::IDX_CTRL)
        && wb_sel_i[0] && wb_dat_i[sgoc_pkg::PAR_CLR_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nxt_odd <= 2'b00;
        end else begin
            if (out_valid_o && out_ready_i && ce_i) begin
                nxt_odd[out_chan_o] <= ~out_odd_o;
            end
            if (par_clr) begin
                nxt_odd <= 2'b00;
            end
        end
    end
    chk_ack_after_req:
        assert property (bus_req |=> wb_ack_o)
        else $error("No ack one cycle after a request");
    chk_ack_pulse:
        assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    chk_ack_cause:
        assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("Ack without request");
    chk_rdat_idle:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("Read data not zero outside ack");
    chk_reset_clear:
        assert property ($fell(rst_i) |-> !wb_ack_o && !out_valid_o)
        else $error("Outputs not clear after reset");
    chk_stall_hold:
        assert property (out_valid_o && !out_ready_i |=> out_valid_o
            && $stable(out_data_o) && $stable({out_chan_o, out_odd_o}))
        else $error("Output changed while stalled");
    chk_take_valid:
        assert property (smp_valid_i && smp_ready_o |=> out_valid_o)
        else $error("Taken sample not presented");
    chk_parity_alt:
        assert property (pop |-> out_odd_o == nxt_odd[out_chan_o])
        else $error("Sample parity did not alternate");
endmodule : sgoc_core_asserts

bind sgoc_core sgoc_core_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i),
    .smp_ready_o(smp_ready_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_data_o(out_data_o),
    .out_chan_o(out_chan_o), .out_odd_o(out_odd_o)
);

// ==== verification/test_sample_gain_offset_correction.sv ====
`timescale 1ns/1ps
module test_sample_gain_offset_correction;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0] idx;
        logic [15:0] val;
        logic chan;
        logic odd;
        logic [13:0] smp;
        logic [13:0] exp;
    } sgoc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, smp_ready_o, out_valid_o, out_chan_o, out_odd_o;
    logic smp_valid_i = 1'b0;
    logic smp_chan_i = 1'b0;
    logic out_ready_i = 1'b1;
    logic [13:0] smp_data_i = 14'h0;
    logic [13:0] out_data_o;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    sgoc_row_t rows [9];

    sgoc_core dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o),
        .smp_data_i(smp_data_i), .smp_chan_i(smp_chan_i),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_data_o(out_data_o), .out_chan_o(out_chan_o),
        .out_odd_o(out_odd_o)
    );

    always #4 clk_i = ~clk_i;

    task automatic end_of_test;
        $display("Checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic cmp_reg(input string what, input logic [31:0] e,
                           input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_reg

    task automatic cmp_smp(input string what, input logic [15:0] e,
                           input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_smp

    // Classic single Wishbone cycle, read data left in rd
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic push(input logic ch, input logic [13:0] d);
        @(posedge clk_i);
        smp_valid_i <= 1'b1;
        smp_chan_i <= ch;
        smp_data_i <= d;
        do @(posedge clk_i); while (smp_ready_o !== 1'b1);
        smp_valid_i <= 1'b0;
    endtask : push

    task automatic pull(input logic ch, input logic od,
                        input logic [13:0] e);
        do @(posedge clk_i); while (out_valid_o !== 1'b1);
        cmp_smp("sample", {ch, od, e}, {out_chan_o, out_odd_o, out_data_o});
    endtask : pull

    initial begin
        rows[0] = '{16'h0000, 8'h34, 16'h0805, 1'b0, 1'b0, 14'h0064, 14'h0064};
        rows[1] = '{16'h0100, 8'h33, 16'h03ff, 1'b0, 1'b1, 14'h0064, 14'h0065};
        rows[2] = '{16'h0100, 8'h34, 16'h0200, 1'b0, 1'b0, 14'h1fff, 14'h1fff};
        rows[3] = '{16'h1000, 8'h35, 16'h2807, 1'b1, 1'b0, 14'h03e8, 14'h03e8};
        rows[4] = '{16'h1000, 8'h35, 16'h2807, 1'b1, 1'b1, 14'h03e8, 14'h0462};
        rows[5] = '{16'h1100, 8'h36, 16'hf801, 1'b1, 1'b0, 14'h0fa1, 14'h1fe7};
        rows[6] = '{16'h1100, 8'h36, 16'hf800, 1'b1, 1'b1, 14'h20c0, 14'h2000};
        rows[7] = '{16'h1100, 8'h36, 16'hf800, 1'b1, 1'b0, 14'h3830, 14'h300d};
        rows[8] = '{16'h0100, 8'h33, 16'hf9ff, 1'b0, 1'b1, 14'h2000, 14'h2000};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(1'b1, 8'h03, rows[i].ctrl);
            wb(1'b1, rows[i].idx, rows[i].val);
            wb(1'b0, rows[i].idx, 16'h0);
            cmp_reg("readback", {16'h0, rows[i].val}, rd);
            push(rows[i].chan, rows[i].smp);
            pull(rows[i].chan, rows[i].odd, rows[i].exp);
            $display("Row %0d done", i);
        end
        wb(1'b0, 8'h03, 16'h0);
        cmp_reg("control", 32'h00000100, rd);
        wb(1'b1, 8'h40, 16'hffff);
        wb(1'b0, 8'h40, 16'h0);
        cmp_reg("unmapped", 32'h0, rd);
        $display("Unmapped access done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wb(1'b0, 8'h33 + k[7:0], 16'h0);
            cmp_reg("reset value", 32'h0, rd);
        end
        $display("Reset values done");
        out_ready_i <= 1'b0;
        push(1'b0, 14'h1234);
        push(1'b0, 14'h2345);
        repeat (3) @(posedge clk_i);
        cmp_reg("ready when full", 32'h0, {31'h0, smp_ready_o});
        out_ready_i <= 1'b1;
        pull(1'b0, 1'b0, 14'h1234);
        pull(1'b0, 1'b1, 14'h2345);
        $display("Stall done");
        wb(1'b0, 8'h3e, 16'h0);
        cmp_reg("status", 32'h00020000, rd);
        push(1'b1, 14'h0100);
        pull(1'b1, 1'b0, 14'h0100);
        wb(1'b0, 8'h3e, 16'h0);
        cmp_reg("status", 32'h00030002, rd);
        wb(1'b1, 8'h03, 16'h0001);
        wb(1'b0, 8'h3e, 16'h0);
        cmp_reg("parity restart", 32'h00030000, rd);
        push(1'b1, 14'h0100);
        pull(1'b1, 1'b0, 14'h0100);
        $display("Parity restart done");
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_reg("frozen ready", 32'h0, {31'h0, smp_ready_o});
        ce_i <= 1'b1;
        push(1'b0, 14'h0010);
        pull(1'b0, 1'b0, 14'h0010);
        $display("Freeze done");
        end_of_test();
    end
endmodule : test_sample_gain_offset_correction
